// File: src/cod_defs.svh
// named constants for the compact operand decoder
`ifndef COD_DEFS_SVH
`define COD_DEFS_SVH

// full register numbers reached by the short forms
`define COD_REG_ZERO  5'h00
`define COD_REG4      5'h04
`define COD_REG5      5'h05
`define COD_REG6      5'h06
`define COD_REG7      5'h07
`define COD_REG16     5'h10
`define COD_REG17     5'h11
`define COD_REG18     5'h12
`define COD_REG19     5'h13
`define COD_REG20     5'h14
`define COD_REG21     5'h15
`define COD_REG22     5'h16

// two-register add-immediate constants
`define COD_AI2_0     32'hffffffff
`define COD_AI2_1     32'h00000001
`define COD_AI2_2     32'h00000004
`define COD_AI2_3     32'h00000008
`define COD_AI2_4     32'h0000000c
`define COD_AI2_5     32'h00000010
`define COD_AI2_6     32'h00000014
`define COD_AI2_7     32'h00000018

// and-mask constants
`define COD_AM_0      32'h00000001
`define COD_AM_1      32'h00000002
`define COD_AM_2      32'h00000003
`define COD_AM_3      32'h00000004
`define COD_AM_4      32'h00000007
`define COD_AM_5      32'h00000008
`define COD_AM_6      32'h0000000f
`define COD_AM_7      32'h00000010
`define COD_AM_8      32'h0000001f
`define COD_AM_9      32'h00000020
`define COD_AM_10     32'h0000003f
`define COD_AM_11     32'h00000040
`define COD_AM_12     32'h00000080
`define COD_AM_13     32'h000000ff
`define COD_AM_14     32'h00008000
`define COD_AM_15     32'h0000ffff

// special codes, bias and scaling shifts
`define COD_ALL_ONES     32'hffffffff
`define COD_LI_NEG_CODE  7'h7f
`define COD_LBU_NEG_CODE 4'hf
`define COD_SPADJ_BIAS   32'h00000002
`define COD_SH_HALF      1
`define COD_SH_WORD      2

`endif

// File: src/cod_operand_decoder.sv
// operand decode stage for compact 16-bit instructions
`timescale 1ns/1ps
`include "cod_defs.svh"

// Overview of operation
// [RL1] two-register add-immediate maps 3-bit code to -1,1,4,8,12,16,20,24
// [RL2] and-mask maps 4-bit code to one of sixteen mask constants
// [RL3] three-register add uses three common-set fields, no immediate
// [RL4] short branch takes 10-bit signed offset shifted left one
// [RL5] branch on zero or nonzero: one register, 7-bit signed offset shifted one
// [RL6] load-immediate: one destination, 7-bit value, -1 or 0 to 126
// [RL7] byte load: base, destination, offset -1 or 0 to 14 unscaled
// [RL8] halfword load scales offset by two, word load by four
// [RL9] stack adjust: 9-bit code to -258..-3 or 2..257, times four
// [RL10] five-bit add-immediate: one 5-bit register both ways, signed -8 to 7
// [RL11] add stack pointer to register: destination, 6-bit unsigned times four
// [RL12] jump and pop stack: 5-bit unsigned times four, no register
// [RL13] global-relative word load: destination, 7-bit signed times four
// [RL14] stack-relative word load: 5-bit destination, 5-bit unsigned times four
// [RL15] load-multiple: 2-bit list and 4-bit unsigned offset times four
// [RL16] pair move: pair code to destination pair, sources from pair set
// [RL17] byte store: base, store-set source, unscaled 4-bit offset
// [RL18] register move: two full 5-bit fields, no immediate
// [RL19] jump-register family: one full 5-bit source, no immediate
// [RL20] read multiplier high or low: one full 5-bit destination
// [RL21] breakpoint passes 4-bit code 0 to 15, no register
// [RL22] common set: codes 0 and 1 give 16 and 17, others unchanged
// [RL23] store set: code 0 gives zero register, 1 gives 17
// [RL24] immediates come out 32 bits, extended and already scaled
// [RL25] every register specifier comes out as a full 5-bit number
module cod_operand_decoder (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    // raw instruction fields from fetch
    input  wire cod_pkg::cod_fields_s fld,
    // decoded operands to execute
    output cod_pkg::cod_dec_s       dec
);

    cod_pkg::cod_dec_s dec_ff;
    cod_pkg::cod_dec_s nxt_dec;
    cod_pkg::cod_reg_t cm_a, cm_b, cm_c, st_b, pr_b, pr_c;
    logic [31:0]       nxt_imm;

    // 3-bit register expanders
    cod_reg3_map u_cm_a (.set(cod_pkg::rset_common),   .code(fld.r3a), .regnum(cm_a));
    cod_reg3_map u_cm_b (.set(cod_pkg::rset_common),   .code(fld.r3b), .regnum(cm_b));
    cod_reg3_map u_cm_c (.set(cod_pkg::rset_common),   .code(fld.r3c), .regnum(cm_c));
    cod_reg3_map u_st_b (.set(cod_pkg::rset_store),    .code(fld.r3b), .regnum(st_b));
    cod_reg3_map u_pr_b (.set(cod_pkg::rset_pair_src), .code(fld.r3b), .regnum(pr_b));
    cod_reg3_map u_pr_c (.set(cod_pkg::rset_pair_src), .code(fld.r3c), .regnum(pr_c));

    // two-register add-immediate table
    function automatic logic [31:0] add2_lut(input logic [2:0] c);
        unique case (c)
            3'h0: add2_lut = `COD_AI2_0;
            3'h1: add2_lut = `COD_AI2_1;
            3'h2: add2_lut = `COD_AI2_2;
            3'h3: add2_lut = `COD_AI2_3;
            3'h4: add2_lut = `COD_AI2_4;
            3'h5: add2_lut = `COD_AI2_5;
            3'h6: add2_lut = `COD_AI2_6;
            3'h7: add2_lut = `COD_AI2_7;
        endcase
    endfunction

    // and-mask table
    function automatic logic [31:0] mask_lut(input logic [3:0] c);
        unique case (c)
            4'h0: mask_lut = `COD_AM_0;
            4'h1: mask_lut = `COD_AM_1;
            4'h2: mask_lut = `COD_AM_2;
            4'h3: mask_lut = `COD_AM_3;
            4'h4: mask_lut = `COD_AM_4;
            4'h5: mask_lut = `COD_AM_5;
            4'h6: mask_lut = `COD_AM_6;
            4'h7: mask_lut = `COD_AM_7;
            4'h8: mask_lut = `COD_AM_8;
            4'h9: mask_lut = `COD_AM_9;
            4'ha: mask_lut = `COD_AM_10;
            4'hb: mask_lut = `COD_AM_11;
            4'hc: mask_lut = `COD_AM_12;
            4'hd: mask_lut = `COD_AM_13;
            4'he: mask_lut = `COD_AM_14;
            4'hf: mask_lut = `COD_AM_15;
        endcase
    endfunction

    // destination pair table, first and second register packed
    function automatic logic [9:0] pair_lut(input logic [2:0] c);
        unique case (c)
            3'h0: pair_lut = {`COD_REG5, `COD_REG6};
            3'h1: pair_lut = {`COD_REG5, `COD_REG7};
            3'h2: pair_lut = {`COD_REG6, `COD_REG7};
            3'h3: pair_lut = {`COD_REG4, `COD_REG21};
            3'h4: pair_lut = {`COD_REG4, `COD_REG22};
            3'h5: pair_lut = {`COD_REG4, `COD_REG5};
            3'h6: pair_lut = {`COD_REG4, `COD_REG6};
            3'h7: pair_lut = {`COD_REG4, `COD_REG7};
        endcase
    endfunction

    // extended immediate forms
    wire [31:0] imm_s4  = {{28{fld.imm[3]}}, fld.imm[3:0]};
    wire [31:0] imm_s7  = {{25{fld.imm[6]}}, fld.imm[6:0]};
    wire [31:0] imm_s9  = {{23{fld.imm[8]}}, fld.imm[8:0]};
    wire [31:0] imm_s10 = {{22{fld.imm[9]}}, fld.imm};
    wire [31:0] imm_u4  = {28'h0, fld.imm[3:0]};
    wire [31:0] imm_u5  = {27'h0, fld.imm[4:0]};
    wire [31:0] imm_u6  = {26'h0, fld.imm[5:0]};
    wire [31:0] imm_u7  = {25'h0, fld.imm[6:0]};
    wire [9:0]  pair    = pair_lut(fld.r3a);

    // special-code immediates
    wire [31:0] li_val  = (fld.imm[6:0] == `COD_LI_NEG_CODE) ? `COD_ALL_ONES : imm_u7; // see [RL6]
    wire [31:0] lbu_val = (fld.imm[3:0] == `COD_LBU_NEG_CODE) ? `COD_ALL_ONES : imm_u4; // see [RL7]
    wire [31:0] spa_val = fld.imm[8] ? imm_s9 - `COD_SPADJ_BIAS
                                     : imm_s9 + `COD_SPADJ_BIAS; // see [RL9]

    // operand class decode
    wire op_r5_jump = fld.op inside {cod_pkg::op_short_jump_link_reg,
                                     cod_pkg::op_short_jump_link_reg_shortslot,
                                     cod_pkg::op_short_jump_reg,
                                     cod_pkg::op_compact_jump_reg}; // see [RL19]
    wire op_r5_dst  = fld.op inside {cod_pkg::op_load_word_stack_rel,
                                     cod_pkg::op_short_read_mul_high,
                                     cod_pkg::op_short_read_mul_low,
                                     cod_pkg::op_short_reg_move}; // see [RL14] [RL18] [RL20]
    wire op_two_reg = fld.op inside {cod_pkg::op_add_imm_two_reg,
                                     cod_pkg::op_short_and,
                                     cod_pkg::op_short_and_mask,
                                     cod_pkg::op_short_invert,
                                     cod_pkg::op_short_or,
                                     cod_pkg::op_short_load_byte_unsigned,
                                     cod_pkg::op_short_load_half_unsigned,
                                     cod_pkg::op_short_load_word};
    wire op_a_dst   = fld.op inside {cod_pkg::op_add_stack_ptr_to_reg,
                                     cod_pkg::op_short_load_imm,
                                     cod_pkg::op_load_word_global_rel}; // see [RL11] [RL13]
    wire op_a_src   = fld.op inside {cod_pkg::op_short_branch_if_zero,
                                     cod_pkg::op_short_branch_if_nonzero,
                                     cod_pkg::op_short_store_byte}; // see [RL5] [RL17]
    wire op_add5    = fld.op == cod_pkg::op_add_imm_5bit_reg;
    wire op_add3    = fld.op == cod_pkg::op_short_add_three_reg;
    wire op_pair    = fld.op == cod_pkg::op_reg_pair_move;
    wire op_move    = fld.op == cod_pkg::op_short_reg_move;
    wire op_store   = fld.op == cod_pkg::op_short_store_byte;

    // source register selection, all full 5-bit numbers
    assign nxt_dec.use_rs1 = op_add5 | op_r5_jump | op_move | op_two_reg | op_add3
                           | op_a_src | op_pair;
    assign nxt_dec.rs1 = (op_add5 | op_r5_jump) ? fld.r5a : // see [RL10] [RL19] [RL25]
                         op_move ? fld.r5b :                // see [RL18]
                         op_pair ? pr_b :                   // see [RL16]
                         cm_a;                              // see [RL3] [RL22]
    assign nxt_dec.use_rs2 = op_add3 | op_store | op_pair;
    assign nxt_dec.rs2 = op_store ? st_b : // see [RL17] [RL23]
                         op_pair ? pr_c :  // see [RL16]
                         cm_b;             // see [RL3]

    // destination register selection
    assign nxt_dec.use_rd = op_add5 | op_r5_dst | op_two_reg | op_a_dst | op_add3 | op_pair;
    assign nxt_dec.rd = (op_add5 | op_r5_dst) ? fld.r5a : // see [RL10] [RL14] [RL20]
                        op_a_dst ? cm_a :                 // see [RL6] [RL11] [RL13]
                        op_add3 ? cm_c :                  // see [RL3]
                        op_pair ? pair[9:5] :             // see [RL16]
                        cm_b;                             // see [RL7] [RL8]
    assign nxt_dec.use_rd2 = op_pair;
    assign nxt_dec.rd2 = op_pair ? pair[4:0] : `COD_REG_ZERO; // see [RL16]

    // pass-through fields
    assign nxt_dec.vld  = fld.vld;
    assign nxt_dec.op   = fld.op;
    assign nxt_dec.list = (fld.op == cod_pkg::op_short_load_multiple) ? fld.list : 2'h0; // see [RL15]
    assign nxt_dec.use_imm = !(op_r5_jump | op_r5_dst | op_pair | op_add3 |
                               fld.op inside {cod_pkg::op_short_and,
                                              cod_pkg::op_short_invert,
                                              cod_pkg::op_short_or,
                                              cod_pkg::op_none})
                             | (fld.op == cod_pkg::op_load_word_stack_rel);
    assign nxt_dec.imm  = nxt_imm;

    // immediate value per form, extended and scaled
    always_comb begin
        unique case (fld.op)
            cod_pkg::op_add_imm_5bit_reg:        nxt_imm = imm_s4;                  // see [RL10]
            cod_pkg::op_stack_ptr_adjust:        nxt_imm = spa_val << `COD_SH_WORD; // see [RL9]
            cod_pkg::op_add_imm_two_reg:         nxt_imm = add2_lut(fld.imm[2:0]);  // see [RL1]
            cod_pkg::op_add_stack_ptr_to_reg:    nxt_imm = imm_u6 << `COD_SH_WORD;  // see [RL11]
            cod_pkg::op_short_and_mask:          nxt_imm = mask_lut(fld.imm[3:0]);  // see [RL2]
            cod_pkg::op_short_branch:            nxt_imm = imm_s10 << `COD_SH_HALF; // see [RL4]
            cod_pkg::op_short_branch_if_zero,
            cod_pkg::op_short_branch_if_nonzero: nxt_imm = imm_s7 << `COD_SH_HALF;  // see [RL5]
            cod_pkg::op_short_breakpoint:        nxt_imm = imm_u4;                  // see [RL21]
            cod_pkg::op_jump_reg_pop_stack:      nxt_imm = imm_u5 << `COD_SH_WORD;  // see [RL12]
            cod_pkg::op_short_load_byte_unsigned: nxt_imm = lbu_val;                // see [RL7]
            cod_pkg::op_short_load_half_unsigned: nxt_imm = imm_u4 << `COD_SH_HALF; // see [RL8]
            cod_pkg::op_short_load_imm:          nxt_imm = li_val;                  // see [RL6]
            cod_pkg::op_short_load_word:         nxt_imm = imm_u4 << `COD_SH_WORD;  // see [RL8]
            cod_pkg::op_short_load_multiple:     nxt_imm = imm_u4 << `COD_SH_WORD;  // see [RL15]
            cod_pkg::op_load_word_global_rel:    nxt_imm = imm_s7 << `COD_SH_WORD;  // see [RL13]
            cod_pkg::op_load_word_stack_rel:     nxt_imm = imm_u5 << `COD_SH_WORD;  // see [RL14]
            cod_pkg::op_short_store_byte:        nxt_imm = imm_u4;                  // see [RL17]
            default:                             nxt_imm = 32'h0;                   // see [RL24]
        endcase
    end

    // output stage register
    always_ff @(posedge clk) begin
        if (reset) begin
            dec_ff <= '0;
        end else begin
            dec_ff <= nxt_dec;
        end
    end

    assign dec = dec_ff;

    // checks on the decoded operands
    property p_add2_neg;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_add_imm_two_reg
            && fld.imm[2:0] == 3'h0
        |=> dec.imm == 32'hffffffff && dec.use_imm;
    endproperty
    a_add2_neg: assert property (p_add2_neg) else $error("add2 code 0 not -1"); // see [RL1]

    // lookup tables
    property p_mask_top;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_short_and_mask
            && fld.imm[3:0] == 4'he
        |=> dec.imm == 32'h00008000;
    endproperty
    a_mask_top: assert property (p_mask_top) else $error("mask code 14 wrong"); // see [RL2]

    property p_add3_regs;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_short_add_three_reg
            && fld.r3c == 3'h0 && fld.r3a == 3'h5
        |=> dec.rd == 5'h10 && dec.rs1 == 5'h05 && !dec.use_imm;
    endproperty
    a_add3_regs: assert property (p_add3_regs) else $error("add3 regs wrong"); // see [RL3]

    // branch offsets
    property p_branch_min;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_short_branch
            && fld.imm == 10'h200
        |=> dec.imm == 32'hfffffc00 && !dec.use_rs1;
    endproperty
    a_branch_min: assert property (p_branch_min) else $error("branch offset wrong"); // see [RL4]

    property p_beqz_max;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_short_branch_if_zero
            && fld.imm[6:0] == 7'h3f
        |=> dec.imm == 32'h0000007e;
    endproperty
    a_beqz_max: assert property (p_beqz_max) else $error("beqz offset wrong"); // see [RL5]

    // special -1 codes
    property p_li_neg;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_short_load_imm
            && fld.imm[6:0] == 7'h7f
        |=> dec.imm == 32'hffffffff;
    endproperty
    a_li_neg: assert property (p_li_neg) else $error("li code 127 not -1"); // see [RL6]

    property p_lbu_neg;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_short_load_byte_unsigned
            && fld.imm[3:0] == 4'hf
        |=> dec.imm == 32'hffffffff;
    endproperty
    a_lbu_neg: assert property (p_lbu_neg) else $error("lbu code 15 not -1"); // see [RL7]

    property p_lw_scale;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_short_load_word
            && fld.imm[3:0] == 4'hf
        |=> dec.imm == 32'h0000003c;
    endproperty
    a_lw_scale: assert property (p_lw_scale) else $error("lw scale wrong"); // see [RL8]

    property p_spadj_ends;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_stack_ptr_adjust
            && fld.imm[8:0] == 9'h1ff
        |=> dec.imm == 32'hfffffff4;
    endproperty
    a_spadj_ends: assert property (p_spadj_ends) else $error("stack adjust wrong"); // see [RL9]

    property p_pop_scale;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_jump_reg_pop_stack
            && fld.imm[4:0] == 5'h1f
        |=> dec.imm == 32'h0000007c && !dec.use_rs1;
    endproperty
    a_pop_scale: assert property (p_pop_scale) else $error("pop offset wrong"); // see [RL12]

    // register sets
    property p_pair_dst;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_reg_pair_move
            && fld.r3a == 3'h3
        |=> dec.rd == 5'h04 && dec.rd2 == 5'h15;
    endproperty
    a_pair_dst: assert property (p_pair_dst) else $error("pair decode wrong"); // see [RL16]

    property p_store_zero;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_short_store_byte
            && fld.r3b == 3'h0
        |=> dec.rs2 == 5'h00 && dec.use_rs2;
    endproperty
    a_store_zero: assert property (p_store_zero) else $error("store src wrong"); // see [RL23]

    property p_sp2reg;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_add_stack_ptr_to_reg
            && fld.imm[5:0] == 6'h3f
        |=> dec.imm == 32'h000000fc;
    endproperty
    a_sp2reg: assert property (p_sp2reg) else $error("sp2reg wrong"); // see [RL11]

    property p_brk;
        @(posedge clk) disable iff (reset)
        fld.op == cod_pkg::op_short_breakpoint
            && fld.imm[3:0] == 4'h9
        |=> dec.imm == 32'h00000009;
    endproperty
    a_brk: assert property (p_brk) else $error("break code wrong"); // see [RL21]

    property p_vld_follow;
        @(posedge clk) disable iff (reset)
        fld.vld ##1 !fld.vld |-> dec.vld ##1 !dec.vld;
    endproperty
    a_vld_follow: assert property (p_vld_follow) else $error("valid not delayed"); // see [RL24]

endmodule

// File: src/cod_pkg.sv
// types shared by the compact operand decoder files
package cod_pkg;

    // short instruction forms handed in by the fetch stage
    typedef enum logic [5:0] {
        op_none,
        op_add_imm_5bit_reg,
        op_stack_ptr_adjust,
        op_add_imm_two_reg,
        op_add_stack_ptr_to_reg,
        op_short_add_three_reg,
        op_short_and,
        op_short_and_mask,
        op_short_branch,
        op_short_branch_if_zero,
        op_short_branch_if_nonzero,
        op_short_breakpoint,
        op_short_jump_link_reg,
        op_short_jump_link_reg_shortslot,
        op_jump_reg_pop_stack,
        op_short_jump_reg,
        op_compact_jump_reg,
        op_short_load_byte_unsigned,
        op_short_load_half_unsigned,
        op_short_load_imm,
        op_short_load_word,
        op_short_load_multiple,
        op_load_word_global_rel,
        op_load_word_stack_rel,
        op_short_read_mul_high,
        op_short_read_mul_low,
        op_short_reg_move,
        op_reg_pair_move,
        op_short_invert,
        op_short_or,
        op_short_store_byte
    } cod_op_e;

    // 3-bit register sets
    typedef enum logic [1:0] {rset_common, rset_store, rset_pair_src} cod_rset_e;

    typedef logic [4:0] cod_reg_t;

    // raw fields of one short instruction
    typedef struct packed {
        logic       vld;
        cod_op_e    op;
        logic [2:0] r3a;
        logic [2:0] r3b;
        logic [2:0] r3c;
        logic [4:0] r5a;
        logic [4:0] r5b;
        logic [9:0] imm;
        logic [1:0] list;
    } cod_fields_s;

    // decoded operands
    typedef struct packed {
        logic        vld;
        cod_op_e     op;
        logic        use_rs1;
        logic        use_rs2;
        logic        use_rd;
        logic        use_rd2;
        logic        use_imm;
        cod_reg_t    rs1;
        cod_reg_t    rs2;
        cod_reg_t    rd;
        cod_reg_t    rd2;
        logic [1:0]  list;
        logic [31:0] imm;
    } cod_dec_s;

endpackage

// File: src/cod_reg3_map.sv
// expands one 3-bit register code into a full register number
`timescale 1ns/1ps
`include "cod_defs.svh"

module cod_reg3_map (
    // selection
    input  wire cod_pkg::cod_rset_e set,
    input  wire logic [2:0]         code,
    // expanded register
    output logic [4:0]              regnum
);

    logic [4:0] pair_reg;
    wire  [4:0] low_reg = {2'h0, code};

    // move-pair source set, ascending order
    always_comb begin
        unique case (code)
            3'h0: pair_reg = `COD_REG_ZERO;
            3'h1: pair_reg = 5'h02;
            3'h2: pair_reg = `COD_REG7;
            3'h3: pair_reg = `COD_REG16;
            3'h4: pair_reg = `COD_REG17;
            3'h5: pair_reg = `COD_REG18;
            3'h6: pair_reg = `COD_REG19;
            3'h7: pair_reg = `COD_REG20;
        endcase
    end

    // common and store sets differ only in code 0
    wire [4:0] code0_reg = (set == cod_pkg::rset_store) ? `COD_REG_ZERO : `COD_REG16; // see [RL22] [RL23]
    assign regnum = (set == cod_pkg::rset_pair_src) ? pair_reg :
                    (code == 3'h0) ? code0_reg :
                    (code == 3'h1) ? `COD_REG17 : low_reg; // see [RL22] [RL23]

endmodule

// File: tb/cod_exec_model.sv
// execute-side consumer that latches each decoded operand set
`timescale 1ns/1ps

module cod_exec_model (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // decoded operands from the decoder
    input  wire cod_pkg::cod_dec_s dec,
    // one captured instruction per cycle
    output logic                   got,
    output cod_pkg::cod_dec_s      cap
);
    // take what the decoder shows at each edge, as the pipeline would
    always @(posedge clk) begin
        got <= dec.vld & ~reset;
        cap <= dec;
    end
endmodule

// File: tb/tb_top.sv
// reference decode, stimulus and scoreboard for the compact operand decoder
`timescale 1ns/1ps

module tb_top;
    logic                 clk       = 1'b0;
    logic                 reset     = 1'b1;
    cod_pkg::cod_fields_s fld       = '0;
    cod_pkg::cod_fields_s f;
    cod_pkg::cod_dec_s    dec, cap, ex;
    cod_pkg::cod_dec_s    q [$];
    logic                 got;
    logic [31:0]          rnd       = 32'hbc9faa52;
    int                   err_count = 0;
    int                   compares  = 0;
    // expected tables, indexed by code
    localparam logic [31:0] ai2 [8] = '{32'hffffffff, 32'h1, 32'h4, 32'h8, 32'hc, 32'h10,
                                        32'h14, 32'h18};
    localparam logic [31:0] am [16] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h7, 32'h8, 32'hf,
        32'h10, 32'h1f, 32'h20, 32'h3f, 32'h40, 32'h80, 32'hff, 32'h8000, 32'hffff};
    localparam logic [4:0] ps [8] = '{5'h0, 5'h2, 5'h7, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
    localparam logic [4:0] pa [8] = '{5'h5, 5'h5, 5'h6, 5'h4, 5'h4, 5'h4, 5'h4, 5'h4};
    localparam logic [4:0] pb [8] = '{5'h6, 5'h7, 5'h7, 5'h15, 5'h16, 5'h5, 5'h6, 5'h7};
    // use flags rs1,rs2,rd,rd2,imm in the order of the form list
    localparam logic [4:0] ut [31] = '{5'h00, 5'h15, 5'h01, 5'h15, 5'h05, 5'h1c, 5'h14, 5'h15,
        5'h01, 5'h11, 5'h11, 5'h01, 5'h10, 5'h10, 5'h01, 5'h10, 5'h10, 5'h15, 5'h15, 5'h05,
        5'h15, 5'h01, 5'h05, 5'h05, 5'h04, 5'h04, 5'h14, 5'h1e, 5'h14, 5'h14, 5'h19};
    localparam logic [9:0] bnd [5] = '{10'h3ff, 10'h000, 10'h200, 10'h1ff, 10'h07e};

    // clock generation
    always #12.5 clk = ~clk;

    cod_operand_decoder dut (.clk(clk), .reset(reset), .fld(fld), .dec(dec));
    cod_exec_model exe (.clk(clk), .reset(reset), .dec(dec), .got(got), .cap(cap));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [4:0] cm(input logic [2:0] c);
        return (c < 3'h2) ? {4'h8, c[0]} : {2'h0, c};
    endfunction

    function automatic logic [4:0] st(input logic [2:0] c);
        return (c == 3'h0) ? 5'h00 : (c == 3'h1) ? 5'h11 : {2'h0, c};
    endfunction

    // expected operands worked out from the field rules
    function automatic cod_pkg::cod_dec_s ref_dec(input cod_pkg::cod_fields_s f);
        cod_pkg::cod_dec_s d;
        logic [4:0]  o;
        logic [31:0] z4, s7, s9;
        d = '0;
        o = f.op[4:0];
        z4 = {28'h0, f.imm[3:0]};
        s7 = {{25{f.imm[6]}}, f.imm[6:0]};
        s9 = {{23{f.imm[8]}}, f.imm[8:0]};
        d.vld = f.vld;
        d.op = f.op;
        {d.use_rs1, d.use_rs2, d.use_rd, d.use_rd2, d.use_imm} = ut[o];
        d.rs1 = cm(f.r3a);
        d.rs2 = cm(f.r3b);
        d.rd = cm(f.r3b);
        case (o)
            5'h01, 5'h0c, 5'h0d, 5'h0f, 5'h10, 5'h17, 5'h18, 5'h19: begin
                d.rs1 = f.r5a;
                d.rd = f.r5a;
            end
            5'h1a: begin
                d.rd = f.r5a;
                d.rs1 = f.r5b;
            end
            5'h05: d.rd = cm(f.r3c);
            5'h04, 5'h13, 5'h16: d.rd = cm(f.r3a);
            5'h1e: d.rs2 = st(f.r3b);
            5'h1b: begin
                d.rd = pa[f.r3a];
                d.rd2 = pb[f.r3a];
                d.rs1 = ps[f.r3b];
                d.rs2 = ps[f.r3c];
            end
            default: ;
        endcase
        case (o)
            5'h01: d.imm = {{28{f.imm[3]}}, f.imm[3:0]};
            5'h02: d.imm = (s9[31] ? s9 - 32'h2 : s9 + 32'h2) << 2;
            5'h03: d.imm = ai2[f.imm[2:0]];
            5'h04: d.imm = {26'h0, f.imm[5:0]} << 2;
            5'h07: d.imm = am[f.imm[3:0]];
            5'h08: d.imm = {{22{f.imm[9]}}, f.imm[9:0]} << 1;
            5'h09, 5'h0a: d.imm = s7 << 1;
            5'h0b, 5'h1e: d.imm = z4;
            5'h0e, 5'h17: d.imm = {27'h0, f.imm[4:0]} << 2;
            5'h11: d.imm = (f.imm[3:0] == 4'hf) ? 32'hffffffff : z4;
            5'h12: d.imm = z4 << 1;
            5'h13: d.imm = (f.imm[6:0] == 7'h7f) ? 32'hffffffff : {25'h0, f.imm[6:0]};
            5'h14, 5'h15: d.imm = z4 << 2;
            5'h16: d.imm = s7 << 2;
            default: ;
        endcase
        if (o == 5'h15) d.list = f.list;
        return d;
    endfunction

    // blank the register fields that the form does not use
    function automatic cod_pkg::cod_dec_s msk(input cod_pkg::cod_dec_s d, input cod_pkg::cod_dec_s e);
        msk = d;
        if (!e.use_rs1) msk.rs1 = '0;
        if (!e.use_rs2) msk.rs2 = '0;
        if (!e.use_rd) msk.rd = '0;
        if (!e.use_rd2) msk.rd2 = '0;
    endfunction

    task automatic give_verdict;
        if (q.size() > 0) err_count++;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // scoreboard: oldest note against each captured result
    always @(negedge clk) begin
        if (got === 1'b1) begin
            ex = '0;
            if (q.size() > 0) ex = q.pop_front();
            compares++;
            if (msk(cap, ex) !== msk(ex, ex)) begin
                err_count++;
                $display("[FAIL] %0t got %h exp %h", $time, cap, ex);
            end
        end
    end

    // every form, boundary immediates first, then random fields
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        compares++;
        if (dec !== '0) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, dec, 1'h0);
        end
        for (int o = 1; o < 31; o++) begin
            for (int i = 0; i < 24; i++) begin
                @(posedge clk);
                rnd = xs(rnd);
                f.vld = (i < 5) | rnd[31] | rnd[30];
                f.op = cod_pkg::cod_op_e'(o);
                f.r3a = i[2:0];
                f.r3b = rnd[2:0];
                f.r3c = rnd[5:3];
                f.r5a = rnd[10:6];
                f.r5b = rnd[15:11];
                f.imm = (i < 5) ? bnd[i] : {rnd[21:16], i[3:0]};
                f.list = rnd[23:22];
                fld <= f;
                if (f.vld) q.push_back(ref_dec(f));
            end
        end
        @(posedge clk);
        fld <= '0;
        repeat (4) @(posedge clk);
        give_verdict();
    end

    // watchdog
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule
